// *** irq_trap_nmi_control.v ***
// Purpose: Interrupt/trap control register, enable flags, trap and non-maskable entry sequencing.
// Assumes: The instruction sequencer shares sys_clk and drives one-cycle strobes.
// Notes:   Vector generation for the maskable response modes lives elsewhere.
`timescale 1ns/100ps
`include "irq_trap_nmi_map.vh"
module irq_trap_nmi_control (
    // Clock and reset.
    input  wire        sys_clk,
    input  wire        rst_n,
    // Internal I/O access from the sequencer.
    input  wire [7:0]  io_addr,
    input  wire        io_wr,
    input  wire        io_rd,
    input  wire [7:0]  io_wdata,
    output reg  [7:0]  io_rdata,
    output reg         io_hit,
    // Undefined opcode reports from the fetch logic.
    input  wire        undef_fetch,
    input  wire        undef_in_mode0_ack,
    input  wire        undef_third_byte,
    // Instruction strobes.
    input  wire        op_irq_disable,
    input  wire        op_irq_enable,
    input  wire        op_nmi_return,
    input  wire        op_maskable_return,
    input  wire        op_read_vector_refresh,
    input  wire        maskable_accept,
    // Machine cycle timing.
    input  wire        sample_strobe,
    input  wire        cycle_end,
    // External pins and internal peripheral requests.
    input  wire        nmi_n,
    input  wire [2:0]  ext_req_n,
    input  wire        internal_req,
    // Gated maskable requests to the sequencer.
    output reg  [2:0]  ext_req_pending,
    output reg         internal_req_pending,
    // Entry sequencing outputs.
    output reg         nmi_ack_start,
    output reg         dma_enable_clear,
    output reg         push_pc,
    output reg         restart_load,
    output reg  [15:0] restart_addr,
    output reg         trap_sequence_state,
    output reg         insert_block,
    output reg         seq_busy,
    // Enable flags and parity load.
    output reg         global_irq_enable,
    output reg         saved_irq_enable,
    output reg         pv_load,
    output reg         pv_value
);

    // Control register fields.
    reg        trap_flag;
    reg        fetch_byte_position;
    reg [2:0]  ext_req_enable;

    // Non-maskable edge detection and latching.
    wire       nmi_sync;
    wire [2:0] ext_sync_n;
    reg        nmi_prev;
    reg        nmi_latched;
    reg        nmi_taken;

    // Entry sequencer.
    reg [2:0]  state;
    reg [2:0]  next_state;

    wire       ctl_sel;
    wire       trap_event;
    wire       nmi_fall;
    wire       nmi_start;

    // Pins are asynchronous, so both pass two flops before any logic looks at them.
    pin_sync #(
        .WIDTH (1)
    ) u_nmi_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin_in  (nmi_n),
        .pin_out (nmi_sync)
    );

    pin_sync #(
        .WIDTH (3)
    ) u_ext_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin_in  (ext_req_n),
        .pin_out (ext_sync_n)
    );

    assign ctl_sel = (io_addr == `CTL_REG_ADDR);

    // Trap sources combined.
    // A trap is not started while another entry is running; the sequencer holds fetch then.
    assign trap_event = (undef_fetch | undef_in_mode0_ack) & (state == `SEQ_IDLE);

    // Falling edge detect.
    // No software bit takes part in this path.
    assign nmi_fall = nmi_prev & ~nmi_sync;

    // Acknowledge at cycle end.
    // Trap wins a tie because it arises inside the current fetch.
    assign nmi_start = nmi_taken & cycle_end & (state == `SEQ_IDLE) & ~trap_event;

    // Previous synchronised level for edge detection.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            nmi_prev <= 1'b1;
        end else begin
            nmi_prev <= nmi_sync;
        end
    end

    // Hold latched edge.
    // The latch survives the pin returning high and clears only when sampled; a new edge
    // in the sampling cycle re-arms it so no request is lost.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            nmi_latched <= 1'b0;
        end else if (nmi_fall) begin
            nmi_latched <= 1'b1;
        end else if (sample_strobe) begin
            nmi_latched <= 1'b0;
        end
    end

    // Sample latched edge.
    // Taken at the sampling point, then kept until the acknowledge can begin.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            nmi_taken <= 1'b0;
        end else if (sample_strobe && nmi_latched) begin
            nmi_taken <= 1'b1;
        end else if (nmi_start) begin
            nmi_taken <= 1'b0;
        end
    end

    // Entry sequencer state register.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= `SEQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // DMA cleared first on a non-maskable entry.
    // Trap runs push, vector, with its flag set as push starts; non-maskable runs DMA stop, push, flags, vector.
    always @* begin
        next_state = state;
        case (state)
            `SEQ_IDLE: begin
                if (trap_event) begin
                    next_state = `SEQ_TRAP_PUSH;
                end else if (nmi_start) begin
                    next_state = `SEQ_NMI_DMA;
                end
            end
            `SEQ_TRAP_PUSH: begin
                next_state = `SEQ_TRAP_VEC;
            end
            `SEQ_TRAP_VEC: begin
                next_state = `SEQ_IDLE;
            end
            `SEQ_NMI_DMA: begin
                next_state = `SEQ_NMI_PUSH;
            end
            `SEQ_NMI_PUSH: begin
                next_state = `SEQ_NMI_FLAGS;
            end
            `SEQ_NMI_FLAGS: begin
                next_state = `SEQ_NMI_VEC;
            end
            `SEQ_NMI_VEC: begin
                next_state = `SEQ_IDLE;
            end
            default: begin
                next_state = `SEQ_IDLE;
            end
        endcase
    end

    // Registered sequencing strobes, one cycle wide except seq_busy, which spans the whole entry.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            nmi_ack_start       <= 1'b0;
            dma_enable_clear    <= 1'b0;
            push_pc             <= 1'b0;
            restart_load        <= 1'b0;
            restart_addr        <= `TRAP_RESTART;
            trap_sequence_state <= 1'b0;
            insert_block        <= 1'b0;
            seq_busy            <= 1'b0;
        end else begin
            nmi_ack_start    <= nmi_start;
            dma_enable_clear <= (next_state == `SEQ_NMI_DMA);
            push_pc          <= (next_state == `SEQ_TRAP_PUSH) | (next_state == `SEQ_NMI_PUSH);
            restart_load     <= (next_state == `SEQ_TRAP_VEC) | (next_state == `SEQ_NMI_VEC);
            seq_busy         <= (next_state != `SEQ_IDLE);
            if (next_state == `SEQ_TRAP_VEC) begin
                restart_addr <= `TRAP_RESTART;
            end else if (next_state == `SEQ_NMI_VEC) begin
                restart_addr <= `NMI_RESTART;
            end
            trap_sequence_state <= (next_state == `SEQ_TRAP_VEC);
            // Block inserted cycles.
            // High in the cycle right after the trap state so no release, refresh, DMA or wait slips in.
            insert_block <= trap_sequence_state;
        end
    end

    // Zero write clears.
    // Hardware set wins over a clearing write in the same cycle.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            trap_flag <= `CTL_TRAP_RESET;
        end else if (trap_event) begin
            trap_flag <= 1'b1;
        end else if (io_wr && ctl_sel && !io_wdata[`CTL_TRAP_BIT]) begin
            trap_flag <= 1'b0;
        end
    end

    // Capture trapping byte.
    // Zero for a second-byte trap, one for a third-byte trap; software cannot write it.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            fetch_byte_position <= `CTL_FBP_RESET;
        end else if (trap_event) begin
            fetch_byte_position <= undef_third_byte;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            ext_req_enable <= `CTL_EN_RESET;
        end else if (io_wr && ctl_sel) begin
            ext_req_enable <= io_wdata[`CTL_EN2_BIT:`CTL_EN0_BIT];
        end
    end

    // Register read port; unmapped addresses read zero and reserved bits read zero.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
            io_hit   <= 1'b0;
        end else begin
            io_hit <= io_rd & ctl_sel;
            if (io_rd && ctl_sel) begin
                io_rdata <= {trap_flag, fetch_byte_position, 3'h0, ext_req_enable};
            end else begin
                io_rdata <= 8'h00;
            end
        end
    end

    // Global and saved enable flags. The strobes are exclusive in a real instruction
    // stream; the entry sequence takes precedence if they ever meet.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            global_irq_enable <= `IEF_RESET;
            saved_irq_enable  <= `IEF_RESET;
        end else if (state == `SEQ_NMI_FLAGS) begin
            saved_irq_enable  <= global_irq_enable;
            global_irq_enable <= 1'b0;
        end else if (maskable_accept) begin
            global_irq_enable <= 1'b0;
            saved_irq_enable  <= 1'b0;
        end else if (op_irq_disable) begin
            global_irq_enable <= 1'b0;
            saved_irq_enable  <= 1'b0;
        end else if (op_irq_enable) begin
            global_irq_enable <= 1'b1;
            saved_irq_enable  <= 1'b1;
        end else if (op_nmi_return) begin
            global_irq_enable <= saved_irq_enable;
        end
        // Trap, maskable return untouched.
        // Neither the trap sequence nor op_maskable_return appears above by intent.
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            pv_load  <= 1'b0;
            pv_value <= 1'b0;
        end else begin
            pv_load <= op_read_vector_refresh;
            if (op_read_vector_refresh) begin
                pv_value <= global_irq_enable;
            end
        end
    end

    // Level requests held.
    // Maskable requests are levels and are not latched, so a requester must hold its line
    // low until acknowledged; nothing is offered from the second cycle of an entry sequence until one cycle after it ends.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            ext_req_pending      <= 3'h0;
            internal_req_pending <= 1'b0;
        end else begin
            ext_req_pending      <= ~ext_sync_n & ext_req_enable & {3{global_irq_enable & ~seq_busy}};
            internal_req_pending <= internal_req & global_irq_enable & ~seq_busy;
        end
    end

    // Maskable return needs no flag action here; the sequencer pops the PC itself.
    wire unused_ok = op_maskable_return;

endmodule

// *** irq_trap_nmi_map.vh ***
// Purpose: Shared constants for the interrupt, trap and non-maskable control block.
// Assumes: Eight-bit I/O data path from the instruction sequencer.
// Notes:   Definitions only; included by bare name.
`ifndef IRQ_TRAP_NMI_MAP_VH
`define IRQ_TRAP_NMI_MAP_VH

// I/O address of the interrupt/trap control register.
`define CTL_REG_ADDR      8'h34

// Field positions inside the interrupt/trap control register.
`define CTL_TRAP_BIT      7
`define CTL_FBP_BIT       6
`define CTL_EN2_BIT       2
`define CTL_EN1_BIT       1
`define CTL_EN0_BIT       0

// Reset values: only the request-zero enable starts set.
`define CTL_EN_RESET      3'h1
`define CTL_TRAP_RESET    1'b0
`define CTL_FBP_RESET     1'b0
`define IEF_RESET         1'b0

// Restart addresses for the trap and the non-maskable request.
`define TRAP_RESTART      16'h0000
`define NMI_RESTART       16'h0066

// Sequencer state codes.
`define SEQ_IDLE          3'h0
`define SEQ_TRAP_PUSH     3'h1
`define SEQ_TRAP_VEC      3'h2
`define SEQ_NMI_DMA       3'h3
`define SEQ_NMI_PUSH      3'h4
`define SEQ_NMI_FLAGS     3'h5
`define SEQ_NMI_VEC       3'h6

`endif

// *** pin_sync.v ***
// Purpose: Two-flop synchroniser for asynchronous pin inputs.
// Assumes: Pins idle high; reset loads the idle level.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/100ps
module pin_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset.
    input  wire             sys_clk,
    input  wire             rst_n,
    // Raw pins and synchronised copy.
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_out
);

    reg [WIDTH-1:0] meta;

    // Two stages in series; reset to the inactive high level so no false edge appears.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            meta    <= {WIDTH{1'b1}};
            pin_out <= {WIDTH{1'b1}};
        end else begin
            meta    <= pin_in;
            pin_out <= meta;
        end
    end

endmodule

// *** irq_requesters.sv ***
// Purpose: Model of the external requesters driving the interrupt pins.
// Assumes: Pins idle high through pull-ups; changes land on the falling clock edge.
// Notes:   A level request is only dropped when the sequencer accepts it.
`timescale 1ns/100ps
module irq_requesters (
    // Clock.
    input  wire       sys_clk,
    // Commands from the bench.
    input  wire [2:0] raise,
    input  wire       nmi_go,
    input  wire       accepted,
    // Pins towards the block.
    output reg  [2:0] ext_req_n,
    output reg        nmi_n
);
    // Pins start released.
    initial begin
        ext_req_n = 3'h7;
        nmi_n     = 1'b1;
    end
    // A slow acknowledge never loses a request, and the edge pin is only a short low pulse.
    // Hold until acknowledged.
    always @(negedge sys_clk) begin
        ext_req_n <= (ext_req_n & ~raise) | {3{accepted}};
        nmi_n     <= ~nmi_go;
    end
endmodule

// *** irq_trap_nmi_control_props.sv ***
// Purpose: Timing and flag relations of the interrupt, trap and edge request block.
// Assumes: Single clock domain, synchronous active-low reset.
// Notes:   Sees only the top-level ports.
`timescale 1ns/100ps
module irq_trap_nmi_control_props (
    // Clock and reset.
    input wire        sys_clk,
    input wire        rst_n,
    // Watched ports.
    input wire        undef_fetch,
    input wire        undef_in_mode0_ack,
    input wire        op_irq_disable,
    input wire        op_irq_enable,
    input wire        op_nmi_return,
    input wire        op_read_vector_refresh,
    input wire        maskable_accept,
    input wire [2:0]  ext_req_pending,
    input wire        nmi_ack_start,
    input wire        dma_enable_clear,
    input wire        push_pc,
    input wire        restart_load,
    input wire [15:0] restart_addr,
    input wire        trap_sequence_state,
    input wire        insert_block,
    input wire        seq_busy,
    input wire        global_irq_enable,
    input wire        saved_irq_enable,
    input wire        pv_load,
    input wire        pv_value
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // A trap is only taken while the sequencer is idle.
    wire trap_go = (undef_fetch | undef_in_mode0_ack) & !seq_busy;
    wire quiet   = !seq_busy & !maskable_accept & !op_irq_disable;
    property p_trap_entry;
        trap_go |=> push_pc && seq_busy ##1 restart_load && trap_sequence_state && restart_addr == 16'h0000;
    endproperty
    a_trap_entry: assert property (p_trap_entry) else $error("trap entry order wrong");
    property p_trap_end;
        trap_sequence_state |=> insert_block && !seq_busy;
    endproperty
    a_trap_end: assert property (p_trap_end) else $error("cycle inserted after trap state");
    property p_nmi_seq;
        nmi_ack_start |-> dma_enable_clear ##1 push_pc ##2 restart_load && restart_addr == 16'h0066;
    endproperty
    a_nmi_seq: assert property (p_nmi_seq) else $error("edge request entry wrong");
    property p_nmi_save;
        nmi_ack_start |-> ##3 !global_irq_enable && saved_irq_enable == $past(global_irq_enable);
    endproperty
    a_nmi_save: assert property (p_nmi_save) else $error("enable not saved");
    property p_enable;
        op_irq_enable && quiet |=> global_irq_enable && saved_irq_enable;
    endproperty
    a_enable: assert property (p_enable) else $error("enable op failed");
    property p_accept;
        maskable_accept && !seq_busy |=> !global_irq_enable && !saved_irq_enable;
    endproperty
    a_accept: assert property (p_accept) else $error("accept left flags set");
    property p_nonmaskable_return_op;
        op_nmi_return && quiet && !op_irq_enable |=> global_irq_enable == $past(saved_irq_enable) && $stable(saved_irq_enable);
    endproperty
    a_nonmaskable_return_op: assert property (p_nonmaskable_return_op) else $error("return did not restore");
    property p_gate;
        |ext_req_pending |-> global_irq_enable || $past(global_irq_enable);
    endproperty
    a_gate: assert property (p_gate) else $error("request passed while disabled");
    property p_parity;
        op_read_vector_refresh |=> pv_load && pv_value == $past(global_irq_enable);
    endproperty
    a_parity: assert property (p_parity) else $error("parity copy wrong");
endmodule
bind irq_trap_nmi_control irq_trap_nmi_control_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .undef_fetch(undef_fetch), .undef_in_mode0_ack(undef_in_mode0_ack), .op_irq_disable(op_irq_disable),
    .op_irq_enable(op_irq_enable), .op_nmi_return(op_nmi_return), .op_read_vector_refresh(op_read_vector_refresh),
    .maskable_accept(maskable_accept), .ext_req_pending(ext_req_pending), .nmi_ack_start(nmi_ack_start),
    .dma_enable_clear(dma_enable_clear), .push_pc(push_pc), .restart_load(restart_load),
    .restart_addr(restart_addr), .trap_sequence_state(trap_sequence_state), .insert_block(insert_block),
    .seq_busy(seq_busy), .global_irq_enable(global_irq_enable), .saved_irq_enable(saved_irq_enable),
    .pv_load(pv_load), .pv_value(pv_value));

// *** irq_trap_nmi_control_test.sv ***
// Purpose: Self-checking bench for the interrupt, trap and edge request block.
// Assumes: Inputs change on the falling clock edge; 50 ns clock.
// Notes:   Operation strobes are one-cycle pulses from a shared vector.
`timescale 1ns/100ps
module irq_trap_nmi_control_test;
    reg         sys_clk, rst_n, io_wr, io_rd, third, nmi_go, internal_req;
    reg  [7:0]  io_addr, io_wdata;
    reg  [9:0]  ops;
    reg  [2:0]  raise;
    wire [7:0]  io_rdata;
    wire [2:0]  ext_req_n, ext_req_pending;
    wire        io_hit, nmi_n, int_pend, nmi_ack_start, pv_load, pv_value, global_irq_enable, saved_irq_enable;
    integer     n_fail, cmp_count;
    irq_requesters far_side (.sys_clk(sys_clk), .raise(raise), .nmi_go(nmi_go), .accepted(ops[5]),
        .ext_req_n(ext_req_n), .nmi_n(nmi_n));
    irq_trap_nmi_control DUT (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit), .undef_fetch(ops[6]),
        .undef_in_mode0_ack(ops[7]), .undef_third_byte(third), .op_irq_disable(ops[0]),
        .op_irq_enable(ops[1]), .op_nmi_return(ops[2]), .op_maskable_return(ops[3]),
        .op_read_vector_refresh(ops[4]), .maskable_accept(ops[5]), .sample_strobe(ops[8]),
        .cycle_end(ops[9]), .nmi_n(nmi_n), .ext_req_n(ext_req_n), .internal_req(internal_req),
        .ext_req_pending(ext_req_pending), .internal_req_pending(int_pend), .nmi_ack_start(nmi_ack_start),
        .dma_enable_clear(), .push_pc(), .restart_load(), .restart_addr(), .trap_sequence_state(),
        .insert_block(), .seq_busy(), .global_irq_enable(global_irq_enable),
        .saved_irq_enable(saved_irq_enable), .pv_load(pv_load), .pv_value(pv_value));
    // Free-running clock.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task wrap_up;
        begin
            if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task pulse(input integer i);
        begin
            @(negedge sys_clk) ops[i] = 1'b1;
            @(negedge sys_clk) ops[i] = 1'b0;
        end
    endtask
    task wr(input [7:0] d);
        begin
            @(negedge sys_clk) {io_addr, io_wdata, io_wr} = {8'h34, d, 1'b1};
            @(negedge sys_clk) io_wr = 1'b0;
        end
    endtask
    // Read data and hit are looked at in the one cycle that they stand.
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(negedge sys_clk) {io_addr, io_rd} = {a, 1'b1};
            @(negedge sys_clk) io_rd = 1'b0;
            chk({7'h00, io_hit, io_rdata}, {7'h00, a == 8'h34, e});
        end
    endtask
    task flags(input [1:0] e);
        chk({14'h0, global_irq_enable, saved_irq_enable}, {14'h0, e});
    endtask
    task t_reset;
        begin
            rd(8'h34, 8'h01);
            flags(2'h0);
            rd(8'h35, 8'h00);
            wr(8'h86);
            rd(8'h34, 8'h06);
            wr(8'h07);
        end
    endtask
    task t_flags;
        begin
            pulse(1);
            flags(2'h3);
            pulse(4);
            chk({14'h0, pv_load, pv_value}, 16'h0003);
            pulse(3);
            flags(2'h3);
            pulse(5);
            flags(2'h0);
            pulse(1);
            pulse(0);
            flags(2'h0);
        end
    endtask
    // Third-byte trap first, then a second-byte trap during a mode-zero acknowledge.
    task t_trap;
        begin
            pulse(1);
            third = 1'b1;
            pulse(6);
            third = 1'b0;
            repeat (3) @(negedge sys_clk);
            rd(8'h34, 8'hC7);
            flags(2'h3);
            wr(8'h87);
            rd(8'h34, 8'hC7);
            wr(8'h47);
            rd(8'h34, 8'h47);
            pulse(7);
            repeat (3) @(negedge sys_clk);
            rd(8'h34, 8'h87);
            wr(8'h07);
        end
    endtask
    // The pin pulse is gone long before sampling, so only the latch can carry it.
    task t_nmi;
        begin
            @(negedge sys_clk) nmi_go = 1'b1;
            @(negedge sys_clk) nmi_go = 1'b0;
            repeat (6) @(negedge sys_clk);
            pulse(9);
            chk({15'h0, nmi_ack_start}, 16'h0000);
            pulse(8);
            pulse(9);
            chk({15'h0, nmi_ack_start}, 16'h0001);
            repeat (5) @(negedge sys_clk);
            flags(2'h1);
            pulse(2);
            flags(2'h3);
        end
    endtask
    task t_req;
        begin
            @(negedge sys_clk) {raise, internal_req} = 4'h7;
            @(negedge sys_clk) raise = 3'h0;
            repeat (4) @(negedge sys_clk);
            chk({12'h0, ext_req_pending, int_pend}, 16'h0007);
            wr(8'h06);
            repeat (2) @(negedge sys_clk);
            chk({12'h0, ext_req_pending, int_pend}, 16'h0005);
            wr(8'h05);
            repeat (2) @(negedge sys_clk);
            chk({12'h0, ext_req_pending, int_pend}, 16'h0003);
            wr(8'h07);
            pulse(0);
            @(negedge sys_clk);
            chk({12'h0, ext_req_pending, int_pend}, 16'h0000);
            pulse(5);
            internal_req = 1'b0;
        end
    endtask
    // Main sequence.
    initial begin
        {rst_n, io_wr, io_rd, third, nmi_go, internal_req} = 6'h00;
        {io_addr, io_wdata, ops, raise} = 29'h0;
        n_fail = 0;
        cmp_count = 0;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset;
        t_flags;
        t_trap;
        t_nmi;
        t_req;
        repeat (4) @(negedge sys_clk);
        wrap_up;
    end
    // The run needs about a hundred cycles; this is ample.
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail = n_fail + 1;
        wrap_up;
    end
endmodule
